// ==== core/fpeb_defines.svh ====
// Constants of the floating-point exception and bounce logic.
// Assumes a 32-bit AHB-Lite register bus and a one-cycle operation port.
// Function
// - Divide-by-zero for finite nonzero dividend over zero
// - Flush mode: subnormal counts as zero here
// - Divzero trap enabled: bounce, registers stay valid
// - Untrapped divzero: signed infinity, set sticky
// - Overflow trap enabled: pessimistic exponent-based detect; the band at the top bounces untrapped too
// - Bounce at maximum exponent or one below
// - Overflow bounce sets exceptional and overflow cause
// - Untrapped overflow result follows rounding mode
// - Untrapped overflow sets overflow and inexact stickies
// - Flush mode: underflow gives +0, no trap
// - No flush: bounce below underflow threshold
// - Underflow bounce sets exceptional and underflow cause
// - No flush: bounce underflow even untrapped
// - Flush decision made before rounding
// - Inexact trap enabled: bounce every data op
// - Inexact untrapped: write result, set sticky
// - Inexact on rounding, untrapped overflow or underflow
// - Bounce NaN without default-NaN, subnormal without flush
`ifndef FPEB_DEFINES_SVH
`define FPEB_DEFINES_SVH
// Register byte offsets
`define FPEB_OFF_SCR 8'h00
`define FPEB_OFF_EXC 8'h04
`define FPEB_OFF_IRQ_STAT 8'h08
`define FPEB_OFF_IRQ_MASK 8'h0C
// Status-control field positions
`define FPEB_SCR_DZ_STICKY 1
`define FPEB_SCR_OF_FLAG 2
`define FPEB_SCR_UF_FLAG 3
`define FPEB_SCR_IX_STICKY 4
`define FPEB_SCR_DZ_EN 9
`define FPEB_SCR_OF_EN 10
`define FPEB_SCR_UF_EN 11
`define FPEB_SCR_IX_EN 12
`define FPEB_SCR_RMODE_LO 22
`define FPEB_SCR_FLUSH 24
`define FPEB_SCR_DEF_NAN 25
// Writable control bits and sticky bits of the status-control register
`define FPEB_SCR_CTRL_MASK 32'h03C01E00
`define FPEB_SCR_STICKY_MASK 32'h0000001E
`define FPEB_SCR_RESET 32'h00000000
// Exception register fields
`define FPEB_EXC_EXCEPTIONAL 31
`define FPEB_EXC_OF_CAUSE 2
`define FPEB_EXC_UF_CAUSE 3
`define FPEB_EXC_MASK 32'h8000000C
`define FPEB_EXC_RESET 32'h00000000
// Interrupt status bits
`define FPEB_IRQ_BOUNCE 0
`define FPEB_IRQ_REFUSE 1
`define FPEB_IRQ_FLAG 2
`define FPEB_IRQ_W 3
`define FPEB_IRQ_RESET 3'h0
// Rounding mode encodings
`define FPEB_RND_NEAREST 2'h0
`define FPEB_RND_UP 2'h1
`define FPEB_RND_DOWN 2'h2
`define FPEB_RND_ZERO 2'h3
// Biased exponent limits
`define FPEB_EXP_MAX_SP 13'h00FF
`define FPEB_EXP_MAX_DP 13'h07FF
`define FPEB_UNF_TH 13'h0001
`endif

// ==== core/fpeb_pkg.sv ====
// Types of the floating-point exception and bounce logic.
// Assumes the operand classification is done by the datapath.
package fpeb_pkg;
  typedef enum logic [2:0] {
    FPEB_CLS_ZERO,
    FPEB_CLS_INF,
    FPEB_CLS_NAN,
    FPEB_CLS_SUB,
    FPEB_CLS_NORM
  } fpeb_cls_e;
  typedef enum logic [1:0] {
    FPEB_RES_COMPUTED,
    FPEB_RES_INF,
    FPEB_RES_MAXFIN,
    FPEB_RES_ZERO
  } fpeb_res_e;
  typedef struct packed {
    logic is_div;
    logic dp;
    fpeb_cls_e a_cls;
    fpeb_cls_e b_cls;
    logic [12:0] exp;
    logic sign;
    logic inexact;
  } fpeb_op_s;
  typedef struct packed {
    fpeb_res_e kind;
    logic sign;
  } fpeb_res_s;
endpackage

// ==== core/fpeb_unit.sv ====
// Exception detection and bounce decision for one data-processing op.
// Assumes the host core presents a classified op for one cycle on OP_VALID.
`timescale 1ns/1ps
`default_nettype none
`include "fpeb_defines.svh"
module fpeb_unit (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  // Operation port from host core
  input wire logic OP_VALID,
  input wire fpeb_pkg::fpeb_op_s OP_INFO,
  output logic OP_DONE,
  output logic OP_BOUNCE,
  output logic OP_REFUSE,
  output fpeb_pkg::fpeb_res_s OP_RES,
  // Interrupt
  output logic IRQ
);

////////////////////////////////////////////////////////////////////////
// Bus slave
logic hready_q;
logic wr_pend_q;
logic [7:0] wr_addr_q;
logic [31:0] hrdata_q;
logic [31:0] scr_q;
logic [31:0] exc_q;
logic [`FPEB_IRQ_W-1:0] irq_stat_q;
logic [`FPEB_IRQ_W-1:0] irq_mask_q;
logic irq_q;

wire addr_ok = HSEL && HREADY && HTRANS[1];
wire rd_take = addr_ok && !HWRITE;
wire wr_take = addr_ok && HWRITE;
wire [7:0] rd_off = HADDR[7:0];
wire rd_scr = rd_off == `FPEB_OFF_SCR;
wire rd_exc = rd_off == `FPEB_OFF_EXC;
wire rd_ist = rd_off == `FPEB_OFF_IRQ_STAT;
wire rd_imk = rd_off == `FPEB_OFF_IRQ_MASK;
wire [31:0] rd_mux =
  rd_scr ? scr_q :
  rd_exc ? exc_q :
  rd_ist ? {29'h0, irq_stat_q} :
  rd_imk ? {29'h0, irq_mask_q} : 32'h0;
wire wr_scr = wr_pend_q && wr_addr_q == `FPEB_OFF_SCR;
wire wr_exc = wr_pend_q && wr_addr_q == `FPEB_OFF_EXC;
wire wr_ist = wr_pend_q && wr_addr_q == `FPEB_OFF_IRQ_STAT;
wire wr_imk = wr_pend_q && wr_addr_q == `FPEB_OFF_IRQ_MASK;

// A write stretches its data phase by one cycle so a following read sees it
always_ff @(posedge CLK_SYS) begin
  if (SRST) begin
    hready_q <= 1'b1;
    wr_pend_q <= 1'b0;
    wr_addr_q <= 8'h00;
    hrdata_q <= 32'h0;
  end else begin
    wr_pend_q <= wr_take;
    hready_q <= !wr_take;
    if (wr_take) begin
      wr_addr_q <= HADDR[7:0];
    end
    if (rd_take) begin
      hrdata_q <= rd_mux;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Control decode
wire dz_en = scr_q[`FPEB_SCR_DZ_EN];
wire of_en = scr_q[`FPEB_SCR_OF_EN];
wire ix_en = scr_q[`FPEB_SCR_IX_EN];
wire flush_zero_bit = scr_q[`FPEB_SCR_FLUSH];
wire default_nan_mode = scr_q[`FPEB_SCR_DEF_NAN];
wire [1:0] rmode = scr_q[`FPEB_SCR_RMODE_LO+1:`FPEB_SCR_RMODE_LO];
wire exceptional = exc_q[`FPEB_EXC_EXCEPTIONAL];

////////////////////////////////////////////////////////////////////////
// Operand classification
fpeb_pkg::fpeb_cls_e a_cls;
fpeb_pkg::fpeb_cls_e b_cls;
assign a_cls = OP_INFO.a_cls;
assign b_cls = OP_INFO.b_cls;
wire a_nan = a_cls == fpeb_pkg::FPEB_CLS_NAN;
wire b_nan = b_cls == fpeb_pkg::FPEB_CLS_NAN;
wire a_sub = a_cls == fpeb_pkg::FPEB_CLS_SUB;
wire b_sub = b_cls == fpeb_pkg::FPEB_CLS_SUB;
// Subnormals read as +0 in flush mode
wire a_zero = a_cls == fpeb_pkg::FPEB_CLS_ZERO || (flush_zero_bit && a_sub);
wire b_zero = b_cls == fpeb_pkg::FPEB_CLS_ZERO || (flush_zero_bit && b_sub);
wire a_inf = a_cls == fpeb_pkg::FPEB_CLS_INF;

wire in_bounce = ((a_nan || b_nan) && !default_nan_mode) ||
                 ((a_sub || b_sub) && !flush_zero_bit);

wire div_zero = OP_INFO.is_div && b_zero && !(a_zero || a_inf || a_nan);

////////////////////////////////////////////////////////////////////////
// Exponent windows
wire signed [12:0] exp_s = $signed(OP_INFO.exp);
wire signed [12:0] exp_max = OP_INFO.dp ? $signed(`FPEB_EXP_MAX_DP) :
                                          $signed(`FPEB_EXP_MAX_SP);
wire signed [12:0] exp_near = exp_max - $signed(13'h0001);
// Rounding or mantissa carry cannot be resolved this close to the top
wire of_zone = exp_s >= exp_near && exp_s <= exp_max;
wire of_beyond = exp_s > exp_max;
wire of_bounce = of_zone || (of_beyond && of_en);
wire of_untrap = of_beyond && !of_en;
// Compared before rounding: exponent 0 with all-ones fraction still flushes
wire uf_low = exp_s < $signed(`FPEB_UNF_TH);
wire uf_bounce = uf_low && !flush_zero_bit;
wire uf_flush = uf_low && flush_zero_bit;

////////////////////////////////////////////////////////////////////////
// Decision, in priority order
wire do_refuse = OP_VALID && exceptional;
wire do_ix_bounce = OP_VALID && !exceptional && ix_en;
wire live = OP_VALID && !exceptional && !ix_en;
wire do_in_bounce = live && in_bounce;
wire live2 = live && !in_bounce;
wire do_dz_bounce = live2 && div_zero && dz_en;
wire do_dz_untrap = live2 && div_zero && !dz_en;
wire live3 = live2 && !div_zero;
wire do_of_bounce = live3 && of_bounce;
wire do_of_untrap = live3 && !of_bounce && of_untrap;
wire live4 = live3 && !of_bounce && !of_untrap;
wire do_uf_bounce = live4 && uf_bounce;
wire do_uf_flush = live4 && uf_flush;
wire do_normal = live4 && !uf_bounce && !uf_flush;

wire any_bounce = do_ix_bounce || do_in_bounce || do_dz_bounce ||
                  do_of_bounce || do_uf_bounce;
wire any_done = do_dz_untrap || do_of_untrap || do_uf_flush || do_normal;

// Untrapped overflow value by rounding mode
logic of_inf;
always_comb begin
  unique case (rmode)
    `FPEB_RND_NEAREST: of_inf = 1'b1;
    `FPEB_RND_UP: of_inf = !OP_INFO.sign;
    `FPEB_RND_DOWN: of_inf = OP_INFO.sign;
    `FPEB_RND_ZERO: of_inf = 1'b0;
  endcase
end

fpeb_pkg::fpeb_res_s res_d;
always_comb begin
  res_d.sign = OP_INFO.sign;
  res_d.kind = fpeb_pkg::FPEB_RES_COMPUTED;
  if (do_dz_untrap) begin
    res_d.kind = fpeb_pkg::FPEB_RES_INF;
  end else if (do_of_untrap) begin
    res_d.kind = of_inf ? fpeb_pkg::FPEB_RES_INF : fpeb_pkg::FPEB_RES_MAXFIN;
  end else if (do_uf_flush) begin
    res_d.kind = fpeb_pkg::FPEB_RES_ZERO;
    res_d.sign = 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////
// Sticky flags; hardware sets win over a same-cycle software write
wire set_dz = do_dz_untrap;
wire set_of = do_of_untrap;
wire set_uf = do_uf_flush;
wire set_ix = do_of_untrap || do_uf_flush || (do_normal && OP_INFO.inexact);
wire [31:0] hw_sticky = ({31'h0, set_dz} << `FPEB_SCR_DZ_STICKY) |
                        ({31'h0, set_of} << `FPEB_SCR_OF_FLAG) |
                        ({31'h0, set_uf} << `FPEB_SCR_UF_FLAG) |
                        ({31'h0, set_ix} << `FPEB_SCR_IX_STICKY);
wire [31:0] scr_keep = wr_scr ?
  (HWDATA & (`FPEB_SCR_CTRL_MASK | `FPEB_SCR_STICKY_MASK)) : scr_q;
wire [31:0] scr_d = scr_keep | hw_sticky;

// Bounces only mark the exception register; status-control stays clean
wire set_exc_flag = any_bounce;
wire [31:0] hw_exc = ({31'h0, set_exc_flag} << `FPEB_EXC_EXCEPTIONAL) |
                     ({31'h0, do_of_bounce} << `FPEB_EXC_OF_CAUSE) |
                     ({31'h0, do_uf_bounce} << `FPEB_EXC_UF_CAUSE);
wire [31:0] exc_keep = wr_exc ? (HWDATA & `FPEB_EXC_MASK) : exc_q;
wire [31:0] exc_d = exc_keep | hw_exc;

////////////////////////////////////////////////////////////////////////
// Interrupts: sticky events, write one to clear, set wins
wire [`FPEB_IRQ_W-1:0] irq_ev = {set_dz || set_of || set_uf || set_ix,
                                 do_refuse, any_bounce};
wire [`FPEB_IRQ_W-1:0] irq_clr = wr_ist ? HWDATA[`FPEB_IRQ_W-1:0] :
                                         {`FPEB_IRQ_W{1'b0}};
wire [`FPEB_IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

always_ff @(posedge CLK_SYS) begin
  if (SRST) begin
    scr_q <= `FPEB_SCR_RESET;
    exc_q <= `FPEB_EXC_RESET;
    irq_stat_q <= `FPEB_IRQ_RESET;
    irq_mask_q <= `FPEB_IRQ_RESET;
    irq_q <= 1'b0;
  end else begin
    scr_q <= scr_d;
    exc_q <= exc_d;
    irq_stat_q <= irq_stat_d;
    if (wr_imk) begin
      irq_mask_q <= HWDATA[`FPEB_IRQ_W-1:0];
    end
    irq_q <= |(irq_stat_d & (wr_imk ? HWDATA[`FPEB_IRQ_W-1:0] : irq_mask_q));
  end
end

////////////////////////////////////////////////////////////////////////
// Operation answer, registered one cycle after OP_VALID
logic done_q;
logic bounce_q;
logic refuse_q;
fpeb_pkg::fpeb_res_s res_q;

always_ff @(posedge CLK_SYS) begin
  if (SRST) begin
    done_q <= 1'b0;
    bounce_q <= 1'b0;
    refuse_q <= 1'b0;
    res_q <= '0;
  end else begin
    done_q <= any_done;
    bounce_q <= any_bounce;
    refuse_q <= do_refuse;
    if (any_done) begin
      res_q <= res_d;
    end
  end
end

assign HREADYOUT = hready_q;
assign HRDATA = hrdata_q;
assign HRESP = 1'b0;
assign OP_DONE = done_q;
assign OP_BOUNCE = bounce_q;
assign OP_REFUSE = refuse_q;
assign OP_RES = res_q;
assign IRQ = irq_q;

endmodule // fpeb_unit
`default_nettype wire

// ==== sim/fpeb_host.sv ====
// Host core model: issues one data op at a time and returns the answer.
// Assumes the unit answers on the same edge that takes the op.
`timescale 1ns/1ps
`default_nettype none
module fpeb_host (
  // Clock
  input wire logic clk,
  // Op port
  output var logic op_valid = 1'h0,
  output var fpeb_pkg::fpeb_op_s op_info = '0,
  input wire logic op_done,
  input wire logic op_bounce,
  input wire logic op_refuse
);
  task automatic issue(input fpeb_pkg::fpeb_op_s o, output logic [2:0] r);
    @(posedge clk);
    op_valid <= 1'h1;
    op_info <= o;
    @(posedge clk);
    op_valid <= 1'h0;
    // Released fields flip so a late sample cannot pass
    op_info <= ~o;
    #1;
    r = {op_done, op_bounce, op_refuse};
  endtask
endmodule // fpeb_host
`default_nettype wire

// ==== sim/fpeb_unit_asserts.sv ====
// Checker of the exception and bounce unit's port behaviour.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "fpeb_defines.svh"
module fpeb_unit_asserts (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // Bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // Op port
  input wire logic OP_VALID,
  input wire fpeb_pkg::fpeb_op_s OP_INFO,
  input wire logic OP_DONE,
  input wire logic OP_BOUNCE,
  input wire logic OP_REFUSE,
  input wire fpeb_pkg::fpeb_res_s OP_RES
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  wire logic take = HSEL & HREADY & HTRANS[1];
  wire logic [12:0] emax = OP_INFO.dp ? `FPEB_EXP_MAX_DP : `FPEB_EXP_MAX_SP;
  // A division by a possible zero is settled ahead of the overflow band
  wire logic dz_op = OP_INFO.is_div && (OP_INFO.b_cls == fpeb_pkg::FPEB_CLS_ZERO ||
                                        OP_INFO.b_cls == fpeb_pkg::FPEB_CLS_SUB);
  ////////////////////////////////////////////////////////////////////////////
  // Software may rewrite the exception flag, so any write ends the watch
  logic exc_seen_q;
  always_ff @(posedge CLK_SYS) begin
    if (SRST || (take && HWRITE)) begin
      exc_seen_q <= 1'h0;
    end else if (OP_BOUNCE) begin
      exc_seen_q <= 1'h1;
    end
  end
  sequence s_wr_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_one_answer;
    $onehot({OP_DONE, OP_BOUNCE, OP_REFUSE});
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_resp_okay: assert property (HRESP == 1'h0) else $error("response not okay");
  a_write_wait: assert property (take && HWRITE |=> s_wr_wait) else $error("write wait wrong");
  a_read_ready: assert property (take && !HWRITE |=> HREADYOUT) else $error("read stalled");
  a_one_answer: assert property (OP_VALID |=> s_one_answer) else $error("not one answer");
  a_no_stray: assert property (!OP_VALID |=> !(OP_DONE || OP_BOUNCE || OP_REFUSE))
    else $error("answer without op");
  a_ovf_band: assert property (
    OP_VALID && !dz_op && (OP_INFO.exp == emax || OP_INFO.exp == emax - 13'h1) |=> !OP_DONE)
    else $error("band op completed");
  a_refuse_hold: assert property (exc_seen_q && OP_VALID |=> OP_REFUSE)
    else $error("op taken while exceptional");
  a_res_hold: assert property (!OP_DONE |-> $stable(OP_RES))
    else $error("result moved without done");
endmodule // fpeb_unit_asserts
bind fpeb_unit fpeb_unit_asserts i_asserts (.CLK_SYS, .SRST, .HSEL, .HTRANS, .HWRITE, .HREADY,
  .HREADYOUT, .HRESP, .OP_VALID, .OP_INFO, .OP_DONE, .OP_BOUNCE, .OP_REFUSE, .OP_RES);
`default_nettype wire

// ==== sim/fpeb_unit_tb.sv ====
// Testbench of the exception and bounce unit: bus and op sequences.
// Assumes the host model drives the op port and the bench the bus.
`timescale 1ns/1ps
`default_nettype none
module fpeb_unit_tb;
  logic clk = 1'h0;
  logic srst = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic op_valid, op_done, op_bounce, op_refuse, irq;
  wire fpeb_pkg::fpeb_op_s op_info;
  wire fpeb_pkg::fpeb_res_s op_res;
  int err_count = 0;
  int n_checks = 0;
  logic [31:0] rv;
  logic [2:0] rsp;
  localparam logic [2:0] CM = 3'h4, BN = 3'h2, RF = 3'h1;
  localparam fpeb_pkg::fpeb_cls_e N = fpeb_pkg::FPEB_CLS_NORM, Z = fpeb_pkg::FPEB_CLS_ZERO;
  localparam fpeb_pkg::fpeb_cls_e Q = fpeb_pkg::FPEB_CLS_NAN, S = fpeb_pkg::FPEB_CLS_SUB;
  localparam fpeb_pkg::fpeb_res_e K_CMP = fpeb_pkg::FPEB_RES_COMPUTED;
  localparam fpeb_pkg::fpeb_res_e K_INF = fpeb_pkg::FPEB_RES_INF;
  localparam fpeb_pkg::fpeb_res_e K_MAX = fpeb_pkg::FPEB_RES_MAXFIN;
  localparam fpeb_pkg::fpeb_res_e K_ZERO = fpeb_pkg::FPEB_RES_ZERO;
  always #2 clk = ~clk;
  fpeb_unit i_dut (.CLK_SYS(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(), .OP_VALID(op_valid), .OP_INFO(op_info), .OP_DONE(op_done),
    .OP_BOUNCE(op_bounce), .OP_REFUSE(op_refuse), .OP_RES(op_res), .IRQ(irq));
  fpeb_host i_host (.clk(clk), .op_valid(op_valid), .op_info(op_info), .op_done(op_done),
    .op_bounce(op_bounce), .op_refuse(op_refuse));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (i > 50) begin
        err_count++;
        tally_and_finish();
      end
    end while (hready !== 1'h1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic op(input fpeb_pkg::fpeb_op_s o, input logic [2:0] e);
    i_host.issue(o, rsp);
    chk({29'h0, rsp}, {29'h0, e});
  endtask
  task automatic cres(input fpeb_pkg::fpeb_res_e k, input logic s);
    chk({29'h0, op_res}, {29'h0, k, s});
  endtask
  task automatic irq_chk(input logic e);
    @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask
  function automatic fpeb_pkg::fpeb_op_s mk(input logic dv, dp, input fpeb_pkg::fpeb_cls_e a, b,
      input logic [12:0] x, input logic s, ix);
    mk = '{dv, dp, a, b, x, s, ix};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    wr(8'h10, 32'hFFFF_FFFF);
    for (int k = 0; k < 5; k++) rd_chk(8'(k * 4), 32'h0);
    $display("reset values done");
    op(mk(1, 0, N, Z, 13'h7F, 1, 0), CM);
    cres(K_INF, 1'h1);
    rd_chk(8'h00, 32'h2);
    irq_chk(1'h0);
    wr(8'h0C, 32'h4);
    irq_chk(1'h1);
    wr(8'h08, 32'h7);
    irq_chk(1'h0);
    wr(8'h00, 32'h0100_0000);
    op(mk(1, 0, N, S, 13'h7F, 0, 0), CM);
    rd_chk(8'h00, 32'h0100_0002);
    wr(8'h00, 32'h0);
    op(mk(1, 0, Z, Z, 13'h7F, 0, 0), CM);
    rd_chk(8'h00, 32'h0);
    wr(8'h00, 32'h200);
    op(mk(1, 0, N, Z, 13'h7F, 0, 0), BN);
    rd_chk(8'h04, 32'h8000_0000);
    op(mk(0, 0, N, N, 13'h7F, 0, 0), RF);
    rd_chk(8'h08, 32'h7);
    wr(8'h04, 32'h0);
    op(mk(0, 0, N, N, 13'h7F, 0, 0), CM);
    $display("divide by zero done");
    wr(8'h00, 32'h0);
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 2; k++) begin
        op(mk(0, d[0], N, N, (d ? 13'h7FF : 13'hFF) - 13'(k), 0, 0), BN);
        rd_chk(8'h04, 32'h8000_0004);
        rd_chk(8'h00, 32'h0);
        wr(8'h04, 32'h0);
      end
    end
    wr(8'h00, 32'h400);
    op(mk(0, 0, N, N, 13'h100, 0, 0), BN);
    rd_chk(8'h04, 32'h8000_0004);
    wr(8'h04, 32'h0);
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        wr(8'h00, 32'(m) << 22);
        op(mk(0, 0, N, N, 13'h100, s[0], 0), CM);
        cres(((m == 0) || (m == 1 && s == 0) || (m == 2 && s == 1)) ? K_INF :
          K_MAX, s[0]);
        rd_chk(8'h00, (32'(m) << 22) | 32'h14);
      end
    end
    $display("overflow done");
    wr(8'h00, 32'h800);
    op(mk(0, 0, N, N, 13'h0, 0, 0), BN);
    rd_chk(8'h04, 32'h8000_0008);
    rd_chk(8'h00, 32'h800);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0100_0800);
    op(mk(0, 0, N, N, 13'h0, 1, 1), CM);
    cres(K_ZERO, 1'h0);
    rd_chk(8'h00, 32'h0100_0818);
    op(mk(0, 0, N, N, 13'h1, 1, 0), CM);
    cres(K_CMP, 1'h1);
    $display("underflow done");
    wr(8'h00, 32'h0);
    op(mk(0, 0, N, N, 13'h7F, 0, 0), CM);
    rd_chk(8'h00, 32'h0);
    op(mk(0, 0, N, N, 13'h7F, 0, 1), CM);
    rd_chk(8'h00, 32'h10);
    wr(8'h00, 32'h1000);
    op(mk(0, 0, N, N, 13'h7F, 0, 0), BN);
    wr(8'h04, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(8'h00, 32'h0);
      op(mk(0, 0, k ? S : Q, N, 13'h7F, 0, 0), BN);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0300_0000);
      op(mk(0, 0, k ? S : Q, N, 13'h7F, 0, 0), CM);
    end
    $display("inexact and input done");
    tally_and_finish();
  end
endmodule // fpeb_unit_tb
`default_nettype wire
